// [src/regulator_consts.svh]
// constants for the regulator mode and fault controller
// assumes a 250 MHz clock and a register port with one-cycle read data
`ifndef REGULATOR_CONSTS_SVH
`define REGULATOR_CONSTS_SVH

`define CLK_MHZ 250
`define RESTART_MS 200
`define RESTART_CYCLES (`RESTART_MS * 1000 * `CLK_MHZ)
`define OV_DEGLITCH_US 10
`define OV_DEGLITCH_CYCLES (`OV_DEGLITCH_US * `CLK_MHZ)
`define SST_SHORT_US 180
`define SST_LONG_US 360
`define SST_SHORT_CYCLES (`SST_SHORT_US * `CLK_MHZ)
`define SST_LONG_CYCLES (`SST_LONG_US * `CLK_MHZ)
`define SEQ_STEP_US 100
`define SEQ_STEP_CYCLES (`SEQ_STEP_US * `CLK_MHZ)
`define STRAP_SETTLE_CYCLES 8

`define ADDR_CTRL 8'h00
`define ADDR_FAULT_CFG 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_FAULT_FLAGS 8'h0C
`define ADDR_LDO1_VA 8'h10
`define ADDR_LDO1_VB 8'h14
`define ADDR_LDO2_V 8'h18
`define ADDR_VSEL_TWO 8'h1C

// fault config bits
`define FC_UV_MASK 0
`define FC_OV_MASK 1
`define FC_SD_DIS 2
`define FAULT_CFG_RESET 8'h03
// control bits
`define CT_DIS_LO 0
`define CT_DIS_HI 3
`define CT_DCH_L1 4
`define CT_DCH_L2 5
`define CT_SST_L1 6
`define CT_SST_L2 7
`define CT_L1_VSEL 8
`define CTRL_RESET 16'h0000

`define VCODE_RESET 6'h18
`endif

// [src/regulator_pkg.sv]
// types for the regulator mode and fault controller
// assumes nothing beyond the constants header
package regulator_pkg;
	typedef enum logic [2:0] {
		st_sample,
		st_sequence,
		st_active,
		st_fault_wait
	} seq_state_type;
endpackage : regulator_pkg

// [src/regulator_mode_fault_control.sv]
// sequencer, mode straps and voltage fault handling for four bucks and two ldos
// assumes comparator outputs and pins are asynchronous; register port on clk
//
// Function
// RULE_01: unmasked bypass undervoltage enters fault state, shuts all regulators down
// RULE_02: after undervoltage shutdown wait 200 ms, restart via power-up sequence
// RULE_03: undervoltage mask resets set; fault only acts once software clears it
// RULE_04: overvoltage qualified only after input above threshold 10 us continuously
// RULE_05: qualified overvoltage turns bypass off, retries 200 ms, if unmasked, enabled
// RULE_06: mode pin low selects buck, high selects bypass for first converter
// RULE_07: mode pins sampled once at startup; later changes ignored
// RULE_08: fourth converter buck or linear; linear uses voltage select two code
// RULE_09: at power up ldos enable in fixed sequence without host command
// RULE_10: in active state each converter disabled by register bit or gpio
// RULE_11: disabled ldo with discharge bit set turns on discharge resistor
// RULE_12: soft-start ramp applied at every ldo enable, including after faults
// RULE_13: soft-start per ldo selects 180 us or 360 us
// RULE_14: first ldo has two voltage registers, second ldo exactly one
// RULE_15: ldo voltage codes are six-bit unsigned, 0.6 V plus code times 50 mV
// RULE_16: bypass power good follows switch comparator and drives undervoltage fault
// RULE_17: undervoltage and overvoltage events latch until status read; code clears them on a fault flags register read, not a status read
`include "regulator_consts.svh"

module regulator_mode_fault_control #(
	parameter int unsigned RESTART_CYCLES = `RESTART_CYCLES,
	parameter int unsigned SEQ_STEP_CYCLES = `SEQ_STEP_CYCLES,
	parameter int unsigned SST_SHORT_CYCLES = `SST_SHORT_CYCLES,
	parameter int unsigned SST_LONG_CYCLES = `SST_LONG_CYCLES,
	parameter logic BUCK4_LDO_DEFAULT = 1'b0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	// asynchronous pins and comparators
	input wire logic mode_pin,
	input wire logic buck4_mode_pin,
	input wire logic buck4_mode_pin_used,
	input wire logic [3:0] gpio_disable,
	input wire logic bypass_power_good,
	input wire logic supply_over_threshold,
	// regulator controls
	output logic [3:0] buck_enable,
	output logic [1:0] ldo_enable,
	output logic [1:0] ldo_discharge,
	output logic [1:0] ldo_softstart,
	output logic [5:0] ldo1_code,
	output logic [5:0] ldo2_code,
	output logic [5:0] buck4_ldo_code,
	output logic bypass_mode,
	output logic buck4_linear,
	output logic voltage_fault_state
);
	import regulator_pkg::*;

	// ************************************************************
	// input synchronisers, three stages, change when stages 2 and 3 agree
	// ************************************************************
	localparam int NSYNC = 9;
	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
	logic [NSYNC-1:0] s1_next, s2_next, s3_next, clean_next;
	assign raw_in = {supply_over_threshold, bypass_power_good, gpio_disable,
		buck4_mode_pin_used, buck4_mode_pin, mode_pin};
	always_comb begin
		s1_next = raw_in;
		s2_next = s1_reg;
		s3_next = s2_reg;
		clean_next = clean_reg;
		for (int i = 0; i < NSYNC; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				clean_next[i] = s3_reg[i];
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			clean_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
			clean_reg <= clean_next;
		end
	end
	logic mode_s, b4mode_s, b4used_s, pgood_s, ov_s;
	logic [3:0] gdis_s;
	assign mode_s = clean_reg[0];
	assign b4mode_s = clean_reg[1];
	assign b4used_s = clean_reg[2];
	assign gdis_s = clean_reg[6:3];
	assign pgood_s = clean_reg[7];
	assign ov_s = clean_reg[8];

	// ************************************************************
	// registers
	// ************************************************************
	logic [15:0] ctrl_reg, ctrl_next;
	logic [2:0] fcfg_reg, fcfg_next;
	logic [1:0] flags_reg, flags_next;
	logic [5:0] l1a_reg, l1a_next, l1b_reg, l1b_next, l2_reg, l2_next, v2_reg, v2_next;
	logic [15:0] rdata_reg, rdata_next;
	logic uv_event, ov_event;
	seq_state_type state_reg, state_next;
	logic bypass_reg, bypass_next, b4lin_reg, b4lin_next;

	always_comb begin
		ctrl_next = ctrl_reg;
		fcfg_next = fcfg_reg;
		l1a_next = l1a_reg;
		l1b_next = l1b_reg;
		l2_next = l2_reg;
		v2_next = v2_reg;
		flags_next = flags_reg;
		rdata_next = 16'h0000;
		if (reg_write) begin
			if (reg_addr == `ADDR_CTRL) begin
				ctrl_next = {7'h00, reg_wdata[8:0]};
			end else if (reg_addr == `ADDR_FAULT_CFG) begin
				fcfg_next = reg_wdata[2:0]; // RULE_03
			end else if (reg_addr == `ADDR_LDO1_VA) begin
				l1a_next = reg_wdata[5:0]; // RULE_15
			end else if (reg_addr == `ADDR_LDO1_VB) begin
				l1b_next = reg_wdata[5:0]; // RULE_14
			end else if (reg_addr == `ADDR_LDO2_V) begin
				l2_next = reg_wdata[5:0]; // RULE_14
			end else if (reg_addr == `ADDR_VSEL_TWO) begin
				v2_next = reg_wdata[5:0];
			end
		end
		if (reg_read) begin
			if (reg_addr == `ADDR_CTRL) begin
				rdata_next = ctrl_reg;
			end else if (reg_addr == `ADDR_FAULT_CFG) begin
				rdata_next = {13'h0000, fcfg_reg};
			end else if (reg_addr == `ADDR_STATUS) begin
				rdata_next = {8'h00, pgood_s, b4lin_reg, bypass_reg,
					(state_reg == st_fault_wait), (state_reg == st_active),
					ldo_enable, 1'b0};
			end else if (reg_addr == `ADDR_FAULT_FLAGS) begin
				rdata_next = {14'h0000, flags_reg};
				flags_next = 2'b00; // RULE_17
			end else if (reg_addr == `ADDR_LDO1_VA) begin
				rdata_next = {10'h000, l1a_reg};
			end else if (reg_addr == `ADDR_LDO1_VB) begin
				rdata_next = {10'h000, l1b_reg};
			end else if (reg_addr == `ADDR_LDO2_V) begin
				rdata_next = {10'h000, l2_reg};
			end else if (reg_addr == `ADDR_VSEL_TWO) begin
				rdata_next = {10'h000, v2_reg};
			end
		end
		// a new event wins over the read that clears
		if (uv_event) begin
			flags_next[0] = 1'b1; // RULE_17
		end
		if (ov_event) begin
			flags_next[1] = 1'b1; // RULE_17
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= `CTRL_RESET;
			fcfg_reg <= 3'(`FAULT_CFG_RESET);
			flags_reg <= 2'b00;
			l1a_reg <= `VCODE_RESET;
			l1b_reg <= `VCODE_RESET;
			l2_reg <= `VCODE_RESET;
			v2_reg <= `VCODE_RESET;
			rdata_reg <= 16'h0000;
		end else begin
			ctrl_reg <= ctrl_next;
			fcfg_reg <= fcfg_next;
			flags_reg <= flags_next;
			l1a_reg <= l1a_next;
			l1b_reg <= l1b_next;
			l2_reg <= l2_next;
			v2_reg <= v2_next;
			rdata_reg <= rdata_next;
		end
	end

	// ************************************************************
	// overvoltage deglitch and bypass retry
	// ************************************************************
	logic [31:0] ovcnt_reg, ovcnt_next, ovret_reg, ovret_next;
	logic ovoff_reg, ovoff_next;
	always_comb begin
		ovcnt_next = 32'h0000_0000;
		ovoff_next = ovoff_reg;
		ovret_next = ovret_reg;
		ov_event = 1'b0;
		if (bypass_reg && ov_s && !ovoff_reg) begin
			ovcnt_next = ovcnt_reg + 32'h0000_0001; // RULE_04
			if (ovcnt_reg == 32'(`OV_DEGLITCH_CYCLES - 1)) begin
				ovcnt_next = 32'h0000_0000;
				if (!fcfg_reg[`FC_OV_MASK] && !fcfg_reg[`FC_SD_DIS]) begin
					ov_event = 1'b1; // RULE_05
					ovoff_next = 1'b1;
					ovret_next = 32'h0000_0000;
				end
			end
		end
		if (ovoff_reg) begin
			ovret_next = ovret_reg + 32'h0000_0001;
			if (ovret_reg == RESTART_CYCLES - 1) begin
				ovoff_next = 1'b0; // RULE_05
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			ovcnt_reg <= 32'h0000_0000;
			ovret_reg <= 32'h0000_0000;
			ovoff_reg <= 1'b0;
		end else begin
			ovcnt_reg <= ovcnt_next;
			ovret_reg <= ovret_next;
			ovoff_reg <= ovoff_next;
		end
	end

	// ************************************************************
	// power sequencer and undervoltage fault
	// ************************************************************
	// steps: buck1, buck2, buck3, buck4, ldo1, ldo2; each waits one step time
	logic [2:0] step_reg, step_next;
	logic [31:0] tmr_reg, tmr_next;
	logic [5:0] on_reg, on_next;
	always_comb begin
		state_next = state_reg;
		step_next = step_reg;
		tmr_next = tmr_reg;
		on_next = on_reg;
		bypass_next = bypass_reg;
		b4lin_next = b4lin_reg;
		uv_event = 1'b0;
		case (state_reg)
			st_sample: begin
				// synchronisers restart empty with reset, so wait until the agree stage holds the pins
				tmr_next = tmr_reg + 32'h0000_0001;
				if (tmr_reg == 32'(`STRAP_SETTLE_CYCLES - 1)) begin
					bypass_next = mode_s; // RULE_06 RULE_07
					b4lin_next = b4used_s ? b4mode_s : BUCK4_LDO_DEFAULT; // RULE_08
					step_next = 3'd0;
					tmr_next = 32'h0000_0000;
					state_next = st_sequence;
				end
			end
			st_sequence: begin
				tmr_next = tmr_reg + 32'h0000_0001;
				if (tmr_reg == SEQ_STEP_CYCLES - 1) begin
					tmr_next = 32'h0000_0000;
					on_next[step_reg] = 1'b1; // RULE_09
					step_next = step_reg + 3'd1;
					if (step_reg == 3'd5) begin
						state_next = st_active;
					end
				end
			end
			st_active: begin
			end
			st_fault_wait: begin
				tmr_next = tmr_reg + 32'h0000_0001;
				if (tmr_reg == RESTART_CYCLES - 1) begin
					tmr_next = 32'h0000_0000;
					step_next = 3'd0;
					state_next = st_sequence; // RULE_02
				end
			end
			default: begin
				state_next = st_sample;
			end
		endcase
		// undervoltage once the bypass switch has been turned on
		if (state_reg != st_fault_wait && state_reg != st_sample && bypass_reg && on_reg[0]
			&& !ovoff_reg && !pgood_s && !fcfg_reg[`FC_UV_MASK]) begin // RULE_03 RULE_16
			uv_event = 1'b1;
			on_next = 6'b00_0000; // RULE_01
			tmr_next = 32'h0000_0000;
			state_next = st_fault_wait; // RULE_01
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= st_sample;
			step_reg <= 3'd0;
			tmr_reg <= 32'h0000_0000;
			on_reg <= 6'b00_0000;
			bypass_reg <= 1'b0;
			b4lin_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			step_reg <= step_next;
			tmr_reg <= tmr_next;
			on_reg <= on_next;
			bypass_reg <= bypass_next;
			b4lin_reg <= b4lin_next;
		end
	end

	// ************************************************************
	// enables, soft-start, discharge and output flops
	// ************************************************************
	logic [5:0] want;
	logic [3:0] dis_any;
	assign dis_any = (state_reg == st_active) ?
		(ctrl_reg[`CT_DIS_HI:`CT_DIS_LO] | gdis_s) : 4'h0; // RULE_10
	assign want = {on_reg[5:4], on_reg[3:0] & ~dis_any};

	logic [1:0] len_prev_reg, len_prev_next;
	logic [1:0] ss_reg, ss_next;
	logic [31:0] sscnt_reg [2];
	logic [31:0] sscnt_next [2];
	logic [3:0] buck_next;
	logic [1:0] ldo_en_next, dch_next;
	logic fault_next;
	always_comb begin
		buck_next = want[3:0];
		buck_next[0] = want[0] && !ovoff_reg; // RULE_05
		ldo_en_next = want[5:4];
		len_prev_next = ldo_en_next;
		ss_next = ss_reg;
		for (int i = 0; i < 2; i++) begin
			sscnt_next[i] = sscnt_reg[i];
			dch_next[i] = !ldo_en_next[i] && ctrl_reg[`CT_DCH_L1 + i]; // RULE_11
			if (ldo_en_next[i] && !len_prev_reg[i]) begin
				ss_next[i] = 1'b1; // RULE_12
				sscnt_next[i] = ctrl_reg[`CT_SST_L1 + i] ?
					SST_LONG_CYCLES : SST_SHORT_CYCLES; // RULE_13
			end else if (!ldo_en_next[i]) begin
				ss_next[i] = 1'b0;
				sscnt_next[i] = 32'h0000_0000;
			end else if (ss_reg[i]) begin
				sscnt_next[i] = sscnt_reg[i] - 32'h0000_0001;
				if (sscnt_reg[i] == 32'h0000_0001) begin
					ss_next[i] = 1'b0;
				end
			end
		end
		fault_next = (state_next == st_fault_wait);
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			len_prev_reg <= 2'b00;
			ss_reg <= 2'b00;
			sscnt_reg[0] <= 32'h0000_0000;
			sscnt_reg[1] <= 32'h0000_0000;
			buck_enable <= 4'h0;
			ldo_enable <= 2'b00;
			ldo_discharge <= 2'b00;
			ldo_softstart <= 2'b00;
			ldo1_code <= `VCODE_RESET;
			ldo2_code <= `VCODE_RESET;
			buck4_ldo_code <= `VCODE_RESET;
			bypass_mode <= 1'b0;
			buck4_linear <= 1'b0;
			voltage_fault_state <= 1'b0;
			reg_rdata <= 16'h0000;
		end else begin
			len_prev_reg <= len_prev_next;
			ss_reg <= ss_next;
			sscnt_reg[0] <= sscnt_next[0];
			sscnt_reg[1] <= sscnt_next[1];
			buck_enable <= buck_next;
			ldo_enable <= ldo_en_next;
			ldo_discharge <= dch_next;
			ldo_softstart <= ss_next;
			ldo1_code <= ctrl_next[`CT_L1_VSEL] ? l1b_next : l1a_next; // RULE_14 RULE_15
			ldo2_code <= l2_next;
			buck4_ldo_code <= v2_next; // RULE_08
			bypass_mode <= bypass_next;
			buck4_linear <= b4lin_next;
			voltage_fault_state <= fault_next;
			reg_rdata <= rdata_next;
		end
	end
endmodule : regulator_mode_fault_control

// [test/regulator_props.sv]
// checker for the regulator controller, bound into every instance
// assumes its parameters follow the instance it is bound into
`include "regulator_consts.svh"
module regulator_props #(
	parameter int unsigned RESTART_CYCLES = 200,
	parameter int unsigned SST_SHORT_CYCLES = 20,
	parameter int unsigned SST_LONG_CYCLES = 40
) (
	// clock, reset and register port
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	// pins and regulator controls
	input wire logic mode_pin,
	input wire logic supply_over_threshold,
	input wire logic [3:0] buck_enable,
	input wire logic [1:0] ldo_enable,
	input wire logic [1:0] ldo_discharge,
	input wire logic [1:0] ldo_softstart,
	input wire logic bypass_mode,
	input wire logic voltage_fault_state
);
	timeunit 1ns;
	timeprecision 1ps;
	// ********
	// shadows of the written bits and run lengths
	// ********
	logic m_uv;
	logic [1:0] dch;
	logic s_pin;
	logic [3:0] s_n;
	logic [11:0] o_n;
	int unsigned f_n;
	int unsigned ss_n;
	always_ff @(posedge clk) begin
		if (rst) begin
			m_uv <= 1'b1;
			dch <= 2'h0;
			s_n <= 4'h0;
			s_pin <= 1'b0;
		end else begin
			if (reg_write && reg_addr == `ADDR_FAULT_CFG) m_uv <= reg_wdata[`FC_UV_MASK];
			if (reg_write && reg_addr == `ADDR_CTRL) dch <= reg_wdata[5:4];
			if (s_n != 4'hF) s_n <= s_n + 4'h1;
			if (s_n == 4'h1) s_pin <= mode_pin;
		end
		f_n <= (rst || !voltage_fault_state) ? 0 : f_n + 1;
		ss_n <= (rst || !ldo_softstart[0]) ? 0 : ss_n + 1;
		o_n <= !supply_over_threshold ? 12'h000 : (o_n == 12'hFFF ? o_n : o_n + 12'h001);
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// ********
	// properties
	// ********
	property p_off;
		voltage_fault_state && $past(voltage_fault_state) |-> buck_enable == 4'h0 && ldo_enable == 2'h0;
	endproperty
	a_off: assert property (p_off) else $error("regulator on in fault wait");
	property p_restart;
		$fell(voltage_fault_state) |-> f_n == RESTART_CYCLES;
	endproperty
	a_restart: assert property (p_restart) else $error("fault wait length wrong");
	property p_mask;
		$rose(voltage_fault_state) |-> !m_uv;
	endproperty
	a_mask: assert property (p_mask) else $error("masked undervoltage acted");
	property p_degl;
		$fell(buck_enable[0]) && o_n != 12'h000 |-> o_n >= 12'h09C4;
	endproperty
	a_degl: assert property (p_degl) else $error("overvoltage not deglitched");
	property p_strap;
		s_n == 4'hF |-> bypass_mode == s_pin;
	endproperty
	a_strap: assert property (p_strap) else $error("mode strap decoded wrong");
	property p_hold;
		s_n == 4'hF |-> $stable(bypass_mode);
	endproperty
	a_hold: assert property (p_hold) else $error("mode changed after startup");
	property p_dch;
		$stable(ldo_enable) && $stable(dch) |-> ldo_discharge == (~ldo_enable & dch);
	endproperty
	a_dch: assert property (p_dch) else $error("discharge wrong");
	property p_ss;
		$fell(ldo_softstart[0]) |-> ss_n == SST_SHORT_CYCLES || ss_n == SST_LONG_CYCLES;
	endproperty
	a_ss: assert property (p_ss) else $error("soft-start length wrong");
endmodule : regulator_props
bind regulator_mode_fault_control regulator_props #(.RESTART_CYCLES(RESTART_CYCLES),
	.SST_SHORT_CYCLES(SST_SHORT_CYCLES), .SST_LONG_CYCLES(SST_LONG_CYCLES)) props (
	.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .mode_pin, .supply_over_threshold,
	.buck_enable, .ldo_enable, .ldo_discharge, .ldo_softstart, .bypass_mode,
	.voltage_fault_state);

// [test/ctrl_pins_model.sv]
// system controller pins: strap held from power-up, gpio and comparator levels
// assumes the bench sets the wanted levels off the clock edge
module ctrl_pins_model #(
	parameter logic STRAP = 1'b1
) (
	// bench requests
	input wire logic flip,
	input wire logic [3:0] dis_req,
	input wire logic good_req,
	input wire logic over_req,
	// pins toward the device
	output logic mode_pin,
	output logic [3:0] gpio_disable,
	output logic bypass_power_good,
	output logic supply_over_threshold
);
	timeunit 1ns;
	timeprecision 1ps;
	// flip breaks the strap on purpose to show that late changes are ignored
	assign mode_pin = STRAP ^ flip;
	assign gpio_disable = dis_req;
	assign bypass_power_good = good_req;
	assign supply_over_threshold = over_req;
endmodule : ctrl_pins_model

// [test/tb.sv]
// self-checking bench for the regulator controller
// assumes the checker binds itself; counts shortened through parameters
`include "regulator_consts.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_total++; \
		$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic flip = 1'b0;
	logic good_req = 1'b1;
	logic over_req = 1'b0;
	logic [3:0] dis_req = 4'h0;
	logic b4_pin = 1'b1;
	logic b4_used = 1'b1;
	logic mode_pin, bypass_power_good, supply_over_threshold;
	logic [3:0] gpio_disable, buck_enable;
	logic [1:0] ldo_enable, ldo_discharge, ldo_softstart;
	logic [5:0] ldo1_code, ldo2_code, buck4_ldo_code;
	logic [15:0] reg_rdata;
	logic bypass_mode, buck4_linear, voltage_fault_state;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #2 clk = ~clk;
	ctrl_pins_model far (.flip, .dis_req, .good_req, .over_req, .mode_pin, .gpio_disable,
		.bypass_power_good, .supply_over_threshold);
	regulator_mode_fault_control #(.RESTART_CYCLES(200), .SEQ_STEP_CYCLES(10),
		.SST_SHORT_CYCLES(20), .SST_LONG_CYCLES(40)) dut (.clk, .rst, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .mode_pin, .buck4_mode_pin(b4_pin),
		.buck4_mode_pin_used(b4_used), .gpio_disable, .bypass_power_good,
		.supply_over_threshold, .buck_enable, .ldo_enable, .ldo_discharge, .ldo_softstart,
		.ldo1_code, .ldo2_code, .buck4_ldo_code, .bypass_mode, .buck4_linear,
		.voltage_fault_state);
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask : rdc
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : hold
	task automatic close_out();
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	// ceiling well above the roughly six thousand cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rdc(`ADDR_LDO1_VA, 16'h0018);
		rdc(`ADDR_FAULT_CFG, 16'h0003);
		rdc(8'h40, 16'h0000);
		hold(80);
		rdc(`ADDR_STATUS, 16'h00EE);
		wr(`ADDR_LDO2_V, 16'h003F);
		wr(`ADDR_VSEL_TWO, 16'h002A);
		wr(`ADDR_LDO1_VB, 16'h0005);
		rdc(`ADDR_LDO2_V, 16'h003F);
		`CHK("ldo2_code", 6'h3F, ldo2_code)
		`CHK("buck4_ldo_code", 6'h2A, buck4_ldo_code)
		wr(`ADDR_CTRL, 16'h0152);
		dis_req <= 4'h4;
		flip <= 1'b1;
		hold(12);
		`CHK("ldo1_code", 6'h05, ldo1_code)
		`CHK("buck_enable", 4'h9, buck_enable)
		`CHK("bypass_mode", 1'b1, bypass_mode)
		`CHK("buck4_linear", 1'b1, buck4_linear)
		good_req <= 1'b0;
		hold(20);
		`CHK("fault_state", 1'b0, voltage_fault_state)
		wr(`ADDR_FAULT_CFG, 16'h0000);
		hold(10);
		`CHK("fault_state", 1'b1, voltage_fault_state)
		`CHK("buck_enable", 4'h0, buck_enable)
		`CHK("ldo_discharge", 2'h1, ldo_discharge)
		good_req <= 1'b1;
		rdc(`ADDR_FAULT_FLAGS, 16'h0001);
		rdc(`ADDR_FAULT_FLAGS, 16'h0000);
		for (int i = 0; i < 600 && ldo_enable[0] !== 1'b1; i++) hold(1);
		hold(2);
		`CHK("ldo_softstart", 2'h1, ldo_softstart)
		hold(30);
		`CHK("ldo_softstart0", 1'b1, ldo_softstart[0])
		hold(40);
		over_req <= 1'b1;
		hold(2400);
		`CHK("buck0", 1'b1, buck_enable[0])
		hold(200);
		`CHK("buck0", 1'b0, buck_enable[0])
		over_req <= 1'b0;
		rdc(`ADDR_FAULT_FLAGS, 16'h0002);
		hold(130);
		`CHK("buck0", 1'b1, buck_enable[0])
		wr(`ADDR_FAULT_CFG, 16'h0004);
		over_req <= 1'b1;
		hold(2600);
		`CHK("buck0", 1'b1, buck_enable[0])
		over_req <= 1'b0;
		rdc(`ADDR_FAULT_FLAGS, 16'h0000);
		close_out();
	end
endmodule : tb
